//--- logic/cmp_channel.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_channel (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   ce,
	input  wire logic                   sys_rst,
	// settings
	input  wire logic                   en,
	input  wire logic [1:0]             hyp_sel,
	input  wire logic [1:0]             hyn_sel,
	input  wire logic [1:0]             resp_mode,
	input  wire logic [1:0]             pos_sel,
	input  wire logic [1:0]             neg_sel,
	// pin levels in millivolts
	input  wire logic [3:0][11:0]       pos_pin_mv,
	input  wire logic [3:0][11:0]       neg_pin_mv,
	// results
	output logic                        raw_out,
	output logic                        latched_out,
	output logic                        rise_evt,
	output logic                        fall_evt
);

	typedef struct packed {
		logic [2:0] sync;
		logic       hyst;
		logic       latched;
		logic       prev;
		logic [3:0] cnt;
	} chan_t;

	chan_t       st_q;
	chan_t       st_d;
	logic [11:0] pos_mv;
	logic [11:0] neg_mv;
	logic [12:0] pos_up;
	logic [12:0] neg_up;

	// ------------------------------------------------------------
	// raw decision, no clock on the input path
	// ------------------------------------------------------------
	// input multiplexers
	assign pos_mv = pos_pin_mv[pos_sel];
	assign neg_mv = neg_pin_mv[neg_sel];
	assign pos_up = {1'b0, pos_mv} + {1'b0, cmp_pkg::hyst_mv(hyn_sel)};
	assign neg_up = {1'b0, neg_mv} + {1'b0, cmp_pkg::hyst_mv(hyp_sel)};
	// compare when enabled, else held low and idle
	// the threshold moves by the hysteresis of the held side
	assign raw_out = en & (st_q.hyst ? (pos_up > {1'b0, neg_mv})
	                                 : ({1'b0, pos_mv} > neg_up));

	// ------------------------------------------------------------
	// synchroniser, response filter, edge detect
	// ------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.hyst = raw_out;
		// three stages, 2nd and 3rd must agree
		st_d.sync = {st_q.sync[1:0], raw_out};
		st_d.prev = st_q.latched;
		if (!en) begin
			st_d.latched = 1'b0;
			st_d.cnt     = 4'h0;
		end else if (st_q.sync[2] == st_q.sync[1]
		             && st_q.sync[2] != st_q.latched) begin
			// slower modes wait longer before the change
			if (st_q.cnt >= cmp_pkg::resp_limit(resp_mode)) begin
				st_d.latched = st_q.sync[2];
				st_d.cnt     = 4'h0;
			end else begin
				st_d.cnt = st_q.cnt + 4'h1;
			end
		end else begin
			st_d.cnt = 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign latched_out = st_q.latched;
	// this sample against the previous one
	assign rise_evt = st_q.latched & ~st_q.prev;
	assign fall_evt = ~st_q.latched & st_q.prev;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_disabled_raw_low: assert property (!en |-> !raw_out)
		else $error("raw result high while disabled");
	chk_plain_compare: assert property (
		en && hyp_sel == 2'h0 && hyn_sel == 2'h0
		|-> raw_out == (pos_mv > neg_mv))
		else $error("raw result differs from plain compare");
	chk_pos_hyst_hold: assert property (
		en && !st_q.hyst && {1'b0, pos_mv} <= neg_up |-> !raw_out)
		else $error("rose inside positive hysteresis");
	chk_neg_hyst_hold: assert property (
		en && st_q.hyst && pos_up > {1'b0, neg_mv} |-> raw_out)
		else $error("fell inside negative hysteresis");
	chk_latched_source: assert property (
		ce && en && st_d.latched != st_q.latched
		|=> latched_out == $past(st_q.sync[2]))
		else $error("latched result not from synchroniser");
	chk_resp_wait: assert property (
		ce && en && st_q.cnt < cmp_pkg::resp_limit(resp_mode)
		|=> latched_out == $past(latched_out))
		else $error("latched result changed before response time");
	chk_edge_pair: assert property (!(rise_evt && fall_evt))
		else $error("rise and fall in one cycle");

endmodule
`default_nettype wire

//--- logic/cmp_pkg.sv
`default_nettype none
package cmp_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int unsigned NCMP   = 2;
	localparam int unsigned NPINS  = 4;
	localparam int unsigned MV_W   = 12;
	localparam int unsigned ADDR_W = 12;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_CTRL0 = 8'h9b;
	localparam logic [7:0] IDX_MODE0 = 8'h9d;
	localparam logic [7:0] IDX_CTRL1 = 8'h9a;
	localparam logic [7:0] IDX_MODE1 = 8'h9c;
	localparam logic [7:0] IDX_SYS   = 8'ha0;
	localparam logic [7:0] IDX_MUX0  = 8'ha1;
	localparam logic [7:0] IDX_MUX1  = 8'ha2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_EN   = 7;
	localparam int unsigned CTRL_OUT  = 6;
	localparam int unsigned CTRL_RIF  = 5;
	localparam int unsigned CTRL_FIF  = 4;
	localparam int unsigned CTRL_HYP  = 2;
	localparam int unsigned CTRL_HYN  = 0;
	localparam int unsigned MODE_RSVD = 7;
	localparam int unsigned MODE_RIE  = 5;
	localparam int unsigned MODE_FIE  = 4;
	localparam int unsigned MODE_MD   = 0;
	localparam int unsigned SYS_GIE   = 0;
	localparam int unsigned SYS_SRC   = 1;
	localparam int unsigned MUX_POS   = 0;
	localparam int unsigned MUX_NEG   = 4;

	// ------------------------------------------------------------
	// reset values, hysteresis and response figures
	// ------------------------------------------------------------
	localparam logic [7:0]  MODE_RST  = 8'h82;
	localparam logic [11:0] HYST_MV_1 = 12'h005;
	localparam logic [11:0] HYST_MV_2 = 12'h00a;
	localparam logic [11:0] HYST_MV_3 = 12'h014;
	localparam logic [3:0]  RESP_CYC_0 = 4'h0;
	localparam logic [3:0]  RESP_CYC_1 = 4'h2;
	localparam logic [3:0]  RESP_CYC_2 = 4'h4;
	localparam logic [3:0]  RESP_CYC_3 = 4'h8;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum {
		SEL_NONE, SEL_CTRL0, SEL_MODE0, SEL_CTRL1,
		SEL_MODE1, SEL_SYS, SEL_MUX0, SEL_MUX1
	} reg_sel_t;

	function automatic reg_sel_t reg_decode(input logic [11:0] addr);
		reg_sel_t s;
		s = SEL_NONE;
		if (addr[11:10] == 2'h0) begin
			case (addr[9:2])
				IDX_CTRL0: s = SEL_CTRL0;
				IDX_MODE0: s = SEL_MODE0;
				IDX_CTRL1: s = SEL_CTRL1;
				IDX_MODE1: s = SEL_MODE1;
				IDX_SYS:   s = SEL_SYS;
				IDX_MUX0:  s = SEL_MUX0;
				IDX_MUX1:  s = SEL_MUX1;
				default:   s = SEL_NONE;
			endcase
		end
		return s;
	endfunction

	function automatic logic [11:0] hyst_mv(input logic [1:0] sel);
		case (sel)
			2'h1:    return HYST_MV_1;
			2'h2:    return HYST_MV_2;
			2'h3:    return HYST_MV_3;
			default: return 12'h000;
		endcase
	endfunction

	function automatic logic [3:0] resp_limit(input logic [1:0] md);
		case (md)
			2'h1:    return RESP_CYC_1;
			2'h2:    return RESP_CYC_2;
			2'h3:    return RESP_CYC_3;
			default: return RESP_CYC_0;
		endcase
	endfunction

endpackage
`default_nettype wire

//--- logic/cmp_top.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_top (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   ce,
	input  wire logic                   sys_rst,
	// axi4-lite write address
	input  wire logic [11:0]            awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	// axi4-lite write data
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	// axi4-lite write response
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	// axi4-lite read
	input  wire logic [11:0]            araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	// pin levels in millivolts, index 0 is comparator_zero
	input  wire logic [1:0][3:0][11:0]  pos_pin_mv,
	input  wire logic [1:0][3:0][11:0]  neg_pin_mv,
	// results
	output logic                        latched_result_zero,
	output logic                        latched_result_one,
	output logic                        raw_result_zero,
	output logic                        raw_result_one,
	output logic                        irq_request
);

	typedef struct packed {
		logic [1:0]      en;
		logic [1:0][1:0] hyp;
		logic [1:0][1:0] hyn;
		logic [1:0][1:0] md;
		logic [1:0]      rie;
		logic [1:0]      fie;
		logic [1:0]      rif;
		logic [1:0]      fif;
		logic            gie;
		logic [1:0]      src;
		logic [1:0][1:0] psel;
		logic [1:0][1:0] nsel;
		logic [11:0]     waddr;
		logic            aw_got;
		logic [7:0]      wbyte;
		logic            wlane;
		logic            w_got;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [7:0]      rbyte;
		logic [1:0]      rresp;
		logic            irq;
	} top_t;

	top_t                st_q;
	top_t                st_d;
	logic [1:0]          raw;
	logic [1:0]          latched;
	logic [1:0]          rise;
	logic [1:0]          fall;
	cmp_pkg::reg_sel_t   wsel;
	cmp_pkg::reg_sel_t   rsel;
	logic                wr;

	// ------------------------------------------------------------
	// comparator channels
	// ------------------------------------------------------------
	// two identical instances
	for (genvar i = 0; i < 2; i++) begin : g_chan
		cmp_channel u_chan (
			.clk         (clk),
			.ce          (ce),
			.sys_rst     (sys_rst),
			.en          (st_q.en[i]),
			.hyp_sel     (st_q.hyp[i]),
			.hyn_sel     (st_q.hyn[i]),
			.resp_mode   (st_q.md[i]),
			.pos_sel     (st_q.psel[i]),
			.neg_sel     (st_q.nsel[i]),
			.pos_pin_mv  (pos_pin_mv[i]),
			.neg_pin_mv  (neg_pin_mv[i]),
			.raw_out     (raw[i]),
			.latched_out (latched[i]),
			.rise_evt    (rise[i]),
			.fall_evt    (fall[i])
		);
	end

	// ------------------------------------------------------------
	// register bus and flags
	// ------------------------------------------------------------
	assign wsel = cmp_pkg::reg_decode(st_q.waddr);
	assign rsel = cmp_pkg::reg_decode(araddr);
	assign wr   = st_q.aw_got && st_q.w_got && !st_q.bvalid;

	always_comb begin
		st_d = st_q;
		// address and data are taken in either order
		if (awvalid && st_q.awready) begin
			st_d.waddr  = awaddr;
			st_d.aw_got = 1'b1;
		end
		if (wvalid && st_q.wready) begin
			st_d.wbyte = wdata[7:0];
			st_d.wlane = wstrb[0];
			st_d.w_got = 1'b1;
		end
		if (st_q.bvalid && bready) begin
			st_d.bvalid = 1'b0;
		end
		if (wr) begin
			st_d.aw_got = 1'b0;
			st_d.w_got  = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp  = (wsel == cmp_pkg::SEL_NONE) ?
			              cmp_pkg::RESP_SLVERR : cmp_pkg::RESP_OKAY;
		end
		for (int i = 0; i < 2; i++) begin
			if (wr && st_q.wlane
			    && wsel == (i == 0 ? cmp_pkg::SEL_CTRL0
			                       : cmp_pkg::SEL_CTRL1)) begin
				st_d.en[i]  = st_q.wbyte[cmp_pkg::CTRL_EN];
				st_d.hyp[i] = st_q.wbyte[cmp_pkg::CTRL_HYP +: 2];
				st_d.hyn[i] = st_q.wbyte[cmp_pkg::CTRL_HYN +: 2];
				// writing zero clears, writing one keeps
				st_d.rif[i] = st_q.rif[i]
				              & st_q.wbyte[cmp_pkg::CTRL_RIF];
				st_d.fif[i] = st_q.fif[i]
				              & st_q.wbyte[cmp_pkg::CTRL_FIF];
			end
			if (wr && st_q.wlane
			    && wsel == (i == 0 ? cmp_pkg::SEL_MODE0
			                       : cmp_pkg::SEL_MODE1)) begin
				// edge interrupt enables in the mode register
				st_d.rie[i] = st_q.wbyte[cmp_pkg::MODE_RIE];
				st_d.fie[i] = st_q.wbyte[cmp_pkg::MODE_FIE];
				st_d.md[i]  = st_q.wbyte[cmp_pkg::MODE_MD +: 2];
			end
			if (wr && st_q.wlane
			    && wsel == (i == 0 ? cmp_pkg::SEL_MUX0
			                       : cmp_pkg::SEL_MUX1)) begin
				st_d.psel[i] = st_q.wbyte[cmp_pkg::MUX_POS +: 2];
				st_d.nsel[i] = st_q.wbyte[cmp_pkg::MUX_NEG +: 2];
			end
			// set regardless of enables, set beats clear
			if (rise[i]) begin
				st_d.rif[i] = 1'b1;
			end
			if (fall[i]) begin
				st_d.fif[i] = 1'b1;
			end
		end
		if (wr && st_q.wlane && wsel == cmp_pkg::SEL_SYS) begin
			st_d.gie = st_q.wbyte[cmp_pkg::SYS_GIE];
			st_d.src = st_q.wbyte[cmp_pkg::SYS_SRC +: 2];
		end
		// one write at a time: no new address or data until answered
		st_d.awready = !st_d.aw_got && !st_d.bvalid;
		st_d.wready  = !st_d.w_got && !st_d.bvalid;

		// read side
		if (st_q.rvalid && rready) begin
			st_d.rvalid = 1'b0;
		end
		if (arvalid && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = cmp_pkg::RESP_OKAY;
			case (rsel)
				// latched result visible as a status bit
				cmp_pkg::SEL_CTRL0: st_d.rbyte = {st_q.en[0],
					latched[0], st_q.rif[0], st_q.fif[0],
					st_q.hyp[0], st_q.hyn[0]};
				cmp_pkg::SEL_CTRL1: st_d.rbyte = {st_q.en[1],
					latched[1], st_q.rif[1], st_q.fif[1],
					st_q.hyp[1], st_q.hyn[1]};
				cmp_pkg::SEL_MODE0: st_d.rbyte = {1'b1, 1'b0,
					st_q.rie[0], st_q.fie[0], 2'h0, st_q.md[0]};
				cmp_pkg::SEL_MODE1: st_d.rbyte = {1'b1, 1'b0,
					st_q.rie[1], st_q.fie[1], 2'h0, st_q.md[1]};
				cmp_pkg::SEL_SYS:   st_d.rbyte = {5'h00, st_q.src,
					st_q.gie};
				cmp_pkg::SEL_MUX0:  st_d.rbyte = {2'h0, st_q.nsel[0],
					2'h0, st_q.psel[0]};
				cmp_pkg::SEL_MUX1:  st_d.rbyte = {2'h0, st_q.nsel[1],
					2'h0, st_q.psel[1]};
				default: begin
					st_d.rbyte = 8'h00;
					st_d.rresp = cmp_pkg::RESP_SLVERR;
				end
			endcase
		end
		st_d.arready = !st_d.rvalid;

		// per-edge enables, source enable, global enable
		st_d.irq = st_q.gie && |(st_q.src
		           & ((st_q.rif & st_q.rie) | (st_q.fif & st_q.fie)));
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q       <= '0;
			st_q.md[0] <= cmp_pkg::MODE_RST[cmp_pkg::MODE_MD +: 2];
			st_q.md[1] <= cmp_pkg::MODE_RST[cmp_pkg::MODE_MD +: 2];
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign awready             = st_q.awready;
	assign wready              = st_q.wready;
	assign bvalid              = st_q.bvalid;
	assign bresp               = st_q.bresp;
	assign arready             = st_q.arready;
	assign rvalid              = st_q.rvalid;
	assign rresp               = st_q.rresp;
	assign rdata               = {24'h000000, st_q.rbyte};
	assign latched_result_zero = latched[0];
	assign latched_result_one  = latched[1];
	// raw results stay valid with the clock stopped
	assign raw_result_zero     = raw[0];
	assign raw_result_one      = raw[1];
	assign irq_request         = st_q.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_rise_sets_flag: assert property (
		ce && rise[0] |=> st_q.rif[0])
		else $error("rising edge did not set flag");
	chk_fall_sets_flag: assert property (
		ce && fall[1] |=> st_q.fif[1])
		else $error("falling edge did not set flag");
	chk_flag_sticky: assert property (
		st_q.rif[0] && !(wr && wsel == cmp_pkg::SEL_CTRL0)
		|=> st_q.rif[0])
		else $error("edge flag dropped without a write");
	// only a fresh update of the request reflects the enables before it
	chk_irq_gating: assert property (
		irq_request && $past(ce)
		|-> $past(st_q.gie) && $past(st_q.src) != 2'h0)
		else $error("interrupt without source and global enables");
	chk_irq_follows: assert property (
		ce && st_q.gie && st_q.src[0] && st_q.fif[0] && st_q.fie[0]
		|=> irq_request)
		else $error("enabled falling flag raised no interrupt");
	chk_write_answer: assert property (
		ce && wr |=> bvalid)
		else $error("write not answered");
	chk_read_answer: assert property (
		ce && arvalid && arready |=> rvalid && !arready)
		else $error("read not answered");
	chk_raw_off: assert property (
		!st_q.en[1] |-> !raw_result_one)
		else $error("raw result one high while disabled");
	chk_rise_flag_one: assert property (
		ce && rise[1] |=> st_q.rif[1])
		else $error("rising edge did not set flag one");
	chk_fall_flag_zero: assert property (
		ce && fall[0] |=> st_q.fif[0])
		else $error("falling edge did not set flag zero");
	chk_fall_sticky: assert property (
		st_q.fif[0] && !(wr && wsel == cmp_pkg::SEL_CTRL0)
		|=> st_q.fif[0])
		else $error("falling flag dropped without a write");
	chk_flag_cleared: assert property (
		ce && wr && st_q.wlane && wsel == cmp_pkg::SEL_CTRL0
		&& !st_q.wbyte[cmp_pkg::CTRL_FIF] && !fall[0]
		|=> !st_q.fif[0])
		else $error("written zero did not clear falling flag");
	chk_irq_rise_path: assert property (
		ce && st_q.gie && st_q.src[0] && st_q.rif[0] && st_q.rie[0]
		|=> irq_request)
		else $error("enabled rising flag raised no interrupt");
	chk_irq_clears: assert property (
		ce && !st_q.gie |=> !irq_request)
		else $error("interrupt with global enable off");

	// bus answers stand until the master takes them
	chk_bvalid_stands: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped before taken");
	chk_rvalid_stands: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped before taken");
	chk_write_blocks: assert property (
		bvalid |-> !awready && !wready)
		else $error("new write offered before answer taken");

	cov_rise_flag: cover property (ce && rise[0] ##1 st_q.rif[0]);
	cov_fall_flag: cover property (ce && fall[1] ##1 st_q.fif[1]);
	cov_irq:       cover property (!irq_request ##1 irq_request);
	cov_read:      cover property (rvalid && rready);
	cov_slverr:    cover property (bvalid && bresp == cmp_pkg::RESP_SLVERR);

endmodule
`default_nettype wire

//--- verif/dual_comparator_edge_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_edge_logic_tb;
	localparam logic [1:0]  OK  = cmp_pkg::RESP_OKAY;
	localparam logic [1:0]  ER  = cmp_pkg::RESP_SLVERR;
	localparam logic [11:0] AC0 = {2'h0, cmp_pkg::IDX_CTRL0, 2'h0};
	localparam logic [11:0] AC1 = {2'h0, cmp_pkg::IDX_CTRL1, 2'h0};
	localparam logic [11:0] AM0 = {2'h0, cmp_pkg::IDX_MODE0, 2'h0};
	localparam logic [11:0] AM1 = {2'h0, cmp_pkg::IDX_MODE1, 2'h0};
	localparam logic [11:0] ASY = {2'h0, cmp_pkg::IDX_SYS, 2'h0};
	localparam logic [11:0] AX0 = {2'h0, cmp_pkg::IDX_MUX0, 2'h0};
	logic clk, ce, sys_rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic lat0, lat1, raw0, raw1;
	logic [11:0] awaddr, araddr, l;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [1:0][11:0]      lvl;
	logic [1:0][3:0][11:0] pos_mv, neg_mv;
	logic [33:0] exp_q[$];
	int n_mismatch, samples_checked;
	logic [11:0] hv [4] = '{12'h000, 12'h005, 12'h00a, 12'h014};
	logic [7:0]  mv [4] = '{8'ha2, 8'ha2, 8'h92, 8'hb2};
	logic [7:0]  sv [4] = '{8'h02, 8'h03, 8'h03, 8'h01};
	logic        iv [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

	pin_model pins (.lvl(lvl), .pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv));
	cmp_top dut (.clk(clk), .ce(ce), .sys_rst(sys_rst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv),
		.latched_result_zero(lat0), .latched_result_one(lat1),
		.raw_result_zero(raw0), .raw_result_one(raw1), .irq_request(irq));

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic chk1(input logic s, input logic e);
		chk({33'h0, s}, {33'h0, e});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic setl(input int c, input logic [11:0] v);
		@(posedge clk);
		lvl[c] <= v;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
			input logic [1:0] r);
		logic aw, w;
		@(posedge clk);
		exp_q.push_back({r, 32'h0});
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awready) begin
				awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w && wready) begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] d,
			input logic [1:0] r);
		@(posedge clk);
		exp_q.push_back({r, 24'h0, d});
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// -------------------------------------------------------------
	// clock, monitor, watchdog
	// -------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// answers are compared in the order they were requested
	always @(posedge clk) begin
		if (rvalid && rready)
			chk({rresp, rdata}, exp_q.pop_front());
		if (bvalid && bready)
			chk({bresp, 32'h0}, exp_q.pop_front());
	end
	initial begin
		#(40 * 40000);
		n_mismatch++;
		print_verdict;
	end

	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	initial begin
		{sys_rst, ce} = 2'h3;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, lvl} = '0;
		wstrb = 4'h1;
		void'($urandom(32'h188f));
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(AC0, 8'h00, OK);
		rd(AM0, 8'h82, OK);
		rd(AC1, 8'h00, OK);
		rd(ASY, 8'h00, OK);
		rd(12'h004, 8'h00, ER);
		wr(12'h004, 8'hff, ER);
		wr(AM1, 8'hff, OK);
		rd(AM1, 8'hb3, OK);
		setl(1, 12'h4b0);
		settle(8);
		chk1(lat1, 1'b0);
		wr(AC1, 8'h80, OK);
		// channel one runs the slowest mode: sync plus eight
		settle(12);
		chk1(lat1, 1'b1);
		chk1(raw1, 1'b1);
		wr(AC0, 8'h80, OK);
		setl(0, 12'h44c);
		#1;
		chk1(raw0, 1'b1);
		chk1(lat0, 1'b0);
		settle(8);
		rd(AC0, 8'he0, OK);
		setl(0, 12'h384);
		settle(8);
		rd(AC0, 8'hb0, OK);
		wr(AC0, 8'hb0, OK);
		rd(AC0, 8'hb0, OK);
		wr(AC0, 8'h80, OK);
		wr(AC0, 8'hb0, OK);
		rd(AC0, 8'h80, OK);
		setl(0, 12'h44c);
		for (int i = 0; i < 4; i++) begin
			wr(AM0, mv[i], OK);
			wr(ASY, sv[i], OK);
			settle(3);
			chk1(irq, iv[i]);
		end
		setl(0, 12'h384);
		wr(AC0, 8'h90, OK);
		wr(AM0, 8'h92, OK);
		wr(ASY, 8'h03, OK);
		settle(3);
		chk1(irq, 1'b1);
		wr(AC0, 8'h80, OK);
		settle(3);
		chk1(irq, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr(AC0, {4'h8, 2'(c), 2'h0}, OK);
			setl(0, 12'h3e8 + hv[c]);
			settle(8);
			chk1(lat0, 1'b0);
			setl(0, 12'h3e9 + hv[c]);
			settle(8);
			chk1(lat0, 1'b1);
			wr(AC0, {4'h8, 2'h0, 2'(c)}, OK);
			setl(0, 12'h3e9 - hv[c]);
			settle(8);
			chk1(lat0, 1'b1);
			setl(0, 12'h3e8 - hv[c]);
			settle(8);
			chk1(lat0, 1'b0);
		end
		wr(AC0, 8'h80, OK);
		for (int m = 0; m < 4; m++) begin
			wr(AM0, 8'h80 | 8'(m), OK);
			setl(0, 12'h44c);
			settle(5);
			if (m == 0 || m == 3)
				chk1(lat0, m == 0);
			settle(12);
			chk1(lat0, 1'b1);
			setl(0, 12'h384);
			settle(14);
		end
		// back to the fastest mode for the timed checks below
		wr(AM0, 8'h80, OK);
		setl(0, 12'h47e);
		settle(8);
		wr(AX0, 8'h02, OK);
		settle(8);
		chk1(lat0, 1'b0);
		wr(AX0, 8'h00, OK);
		settle(8);
		chk1(lat0, 1'b1);
		// clock enable low: raw follows the pins, latched holds
		@(posedge clk);
		ce     <= 1'b0;
		lvl[0] <= 12'h384;
		settle(8);
		chk1(raw0, 1'b0);
		chk1(lat0, 1'b1);
		@(posedge clk);
		ce <= 1'b1;
		settle(8);
		chk1(lat0, 1'b0);
		for (int k = 0; k < 8; k++) begin
			l = 12'h384 + 12'($urandom % 200);
			setl(0, l);
			settle(10);
			chk1(lat0, l > 12'h3e8);
		end
		wr(AC0, 8'h00, OK);
		settle(3);
		chk1(lat0, 1'b0);
		// disabling channel one forces a falling edge
		wr(AC1, 8'h00, OK);
		settle(3);
		chk1(lat1, 1'b0);
		rd(AC1, 8'h30, OK);
		print_verdict;
	end
endmodule
`default_nettype wire

//--- verif/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model (
	// commanded levels in millivolts
	input  wire logic [1:0][11:0]      lvl,
	// pin levels
	output logic      [1:0][3:0][11:0] pos_pin_mv,
	output logic      [1:0][3:0][11:0] neg_pin_mv
);
	// -------------------------------------------------------------
	// pins
	// -------------------------------------------------------------
	// pins behind muxes
	// positive pins step down 100 mV so a wrong positive mux pick shows
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			for (int p = 0; p < 4; p++) begin
				pos_pin_mv[c][p] = lvl[c] - 12'(100 * p);
				neg_pin_mv[c][p] = 12'h3e8;
			end
		end
	end
endmodule
`default_nettype wire
